// ### hdl/sarac_pkg.sv
// constants shared by the converter control and readout logic
// assumes a 100 MHz system clock; the serial clock is a separate domain
package sarac_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int RES_W = 10;
    // sampling monostable, least time rounds up
    localparam int SAMPLE_TIME_NS = 10_000;
    localparam int SAMPLE_CYC = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // internal oscillator of about 250 kHz
    localparam int INT_CLK_HZ = 250_000;
    localparam int INT_CLK_CYC = CLK_HZ / INT_CLK_HZ;
    // slowest external clock that still counts as present
    localparam int EXT_CLK_MIN_HZ = 10_000;
    localparam int EXT_TIMEOUT_CYC = CLK_HZ / EXT_CLK_MIN_HZ;
    localparam logic [3:0] CONV_TICKS = 4'hd;
    localparam logic [3:0] SAR_STEPS = 4'ha;
    localparam logic [9:0] TRIAL_MSB = 10'h0200;
    localparam logic [9:0] RESULT_RST = 10'h0000;
    localparam logic EOC_N_RST = 1'b1;
    localparam logic [3:0] SER_IDX_EMPTY = 4'hf;
    // synchroniser reset follows the idle pins: deselected, read
    localparam logic [6:0] PIN_SYNC_RST = 7'h06;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONVERT = 3'b100
    } sarac_state_e;
endpackage

// ### hdl/sarac_top.sv
// control, clocking and parallel/serial readout of a successive approximation converter
// assumes analog comparator and trial DAC outside; pins arrive asynchronous
module sarac_top
    import sarac_pkg::*;
#(
    parameter int EXT_TIMEOUT = EXT_TIMEOUT_CYC
) (
    // system clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // microcontroller control pins
    input wire logic chip_enable,
    input wire logic chip_select_n,
    input wire logic read_convert,
    input wire logic byte_select,
    input wire logic width_select,
    // conversion clock pin and analog comparator
    input wire logic conversion_clock,
    input wire logic compare_above,
    // analog front end control
    output logic sample_hold,
    output logic [9:0] dac_trial,
    output logic int_clk_run,
    // status and parallel bus
    output logic end_of_conversion_n,
    output logic [9:0] data_out,
    output logic [9:0] data_oe,
    // serial port
    input wire logic serial_clk,
    output logic serial_out,
    output logic serial_oe
);
    // pin synchronisers: stage one feeds stage two only
    logic [6:0] pin_a_ff;
    logic [6:0] pin_b_ff;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            // idle levels, so no false select edge follows reset
            pin_a_ff <= PIN_SYNC_RST;
            pin_b_ff <= PIN_SYNC_RST;
        end else if (clk_en) begin
            pin_a_ff <= {compare_above, conversion_clock, width_select, byte_select,
                         read_convert, chip_select_n, chip_enable};
            pin_b_ff <= pin_a_ff;
        end
    end
    logic ce_s, csn_s, rc_s, bs_s, ws_s, ck_s, cmp_s;
    assign {cmp_s, ck_s, ws_s, bs_s, rc_s, csn_s, ce_s} = pin_b_ff;
    // edge history of synchronised levels
    logic start_prev_ff, csn_prev_ff, ck_prev_ff;
    logic start_cond, start_edge, csn_fall, ck_rise;
    assign start_cond = ce_s & ~csn_s & ~rc_s;
    assign start_edge = start_cond & ~start_prev_ff;
    assign csn_fall = ~csn_s & csn_prev_ff;
    assign ck_rise = ck_s & ~ck_prev_ff;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            start_prev_ff <= 1'b0;
            csn_prev_ff <= 1'b1;
            ck_prev_ff <= 1'b0;
        end else if (clk_en) begin
            start_prev_ff <= start_cond;
            csn_prev_ff <= csn_s;
            ck_prev_ff <= ck_s;
        end
    end
    // external clock presence: any rising edge within the timeout window
    logic [15:0] ext_idle_ff;
    logic ext_present;
    assign ext_present = ext_idle_ff < 16'(EXT_TIMEOUT);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_idle_ff <= 16'hffff;
        end else if (clk_en) begin
            if (ck_rise) begin
                ext_idle_ff <= 16'h0000;
            end else if (ext_idle_ff != 16'hffff) begin
                ext_idle_ff <= ext_idle_ff + 16'h0001;
            end
        end
    end
    // sequencing state
    sarac_state_e state_ff;
    logic [9:0] sample_cnt_ff;
    logic [3:0] tick_cnt_ff;
    logic [8:0] int_div_ff;
    logic width8_ff;
    logic tick, conv_done, busy;
    assign busy = state_ff != ST_IDLE;
    // internal clock is held off whenever an external clock is seen
    assign tick = (state_ff == ST_CONVERT) &&
                  (ext_present ? ck_rise : (int_div_ff == 9'(INT_CLK_CYC - 1)));
    assign conv_done = tick && (tick_cnt_ff == CONV_TICKS - 4'h0001);
    // a new start edge is honoured at any time and restarts sampling
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= ST_IDLE;
        end else if (clk_en) begin
            if (start_edge) begin
                state_ff <= ST_SAMPLE;
            end else begin
                unique case (state_ff)
                    ST_IDLE: state_ff <= ST_IDLE;
                    ST_SAMPLE: begin
                        if (sample_cnt_ff == 10'(SAMPLE_CYC - 1)) begin
                            state_ff <= ST_CONVERT;
                        end
                    end
                    ST_CONVERT: begin
                        if (conv_done) begin
                            state_ff <= ST_IDLE;
                        end
                    end
                    default: state_ff <= ST_IDLE;
                endcase
            end
        end
    end
    // sampling monostable counter
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sample_cnt_ff <= 10'h000;
        end else if (clk_en) begin
            if (start_edge || state_ff != ST_SAMPLE) begin
                sample_cnt_ff <= 10'h000;
            end else begin
                sample_cnt_ff <= sample_cnt_ff + 10'h001;
            end
        end
    end
    // internal oscillator divider and conversion tick counter
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            int_div_ff <= 9'h000;
            tick_cnt_ff <= 4'h0;
        end else if (clk_en) begin
            if (state_ff != ST_CONVERT || start_edge) begin
                int_div_ff <= 9'h000;
                tick_cnt_ff <= 4'h0;
            end else begin
                int_div_ff <= (int_div_ff == 9'(INT_CLK_CYC - 1)) ? 9'h000 : int_div_ff + 9'h001;
                if (tick) begin
                    tick_cnt_ff <= tick_cnt_ff + 4'h1;
                end
            end
        end
    end
    // width latched only on the start edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            width8_ff <= 1'b0;
        end else if (clk_en && start_edge) begin
            width8_ff <= bs_s;
        end
    end
    // successive approximation register, one bit per tick
    logic [9:0] trial_ff;
    logic [9:0] nxt_trial;
    logic [3:0] bit_idx;
    always_comb begin
        nxt_trial = trial_ff;
        bit_idx = 4'(9) - tick_cnt_ff;
        if (tick && tick_cnt_ff < SAR_STEPS) begin
            nxt_trial[bit_idx] = cmp_s;
            // an 8-bit run never tries the two lowest bits
            if (bit_idx != 4'h0 && !(width8_ff && bit_idx <= 4'h2)) begin
                nxt_trial[bit_idx - 4'h1] = 1'b1;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trial_ff <= RESULT_RST;
        end else if (clk_en) begin
            if (state_ff == ST_SAMPLE) begin
                trial_ff <= TRIAL_MSB;
            end else begin
                trial_ff <= nxt_trial;
            end
        end
    end
    // result store and end flag
    logic [9:0] result_ff;
    logic eoc_n_ff, have_result_ff;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            result_ff <= RESULT_RST;
            eoc_n_ff <= EOC_N_RST;
            have_result_ff <= 1'b0;
        end else if (clk_en) begin
            if (start_edge) begin
                eoc_n_ff <= 1'b1;
            end else if (conv_done) begin
                result_ff <= width8_ff ? {nxt_trial[9:2], 2'b00} : nxt_trial;
                eoc_n_ff <= 1'b0;
                have_result_ff <= 1'b1;
            end
        end
    end
    // parallel read path, floats while busy
    logic rd_cond;
    assign rd_cond = ce_s & ~csn_s & rc_s & ~busy;
    logic [9:0] pd_ff, poe_ff;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pd_ff <= 10'h000;
            poe_ff <= 10'h000;
        end else if (clk_en) begin
            if (!rd_cond || start_edge) begin
                pd_ff <= 10'h000;
                poe_ff <= 10'h000;
            end else if (ws_s) begin
                pd_ff <= result_ff;
                poe_ff <= 10'h3ff;
            end else if (!bs_s) begin
                pd_ff <= {result_ff[9:2], 2'b00};
                poe_ff <= 10'h3fc;
            end else begin
                pd_ff <= {result_ff[1:0], 8'h00};
                poe_ff <= 10'h3fc;
            end
        end
    end
    // serial word handed to the serial clock domain by toggle
    logic [9:0] ser_word_ff;
    logic load_tgl_ff;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ser_word_ff <= RESULT_RST;
            load_tgl_ff <= 1'b0;
        end else if (clk_en) begin
            if (conv_done) begin
                ser_word_ff <= width8_ff ? {nxt_trial[9:2], 2'b00} : nxt_trial;
                load_tgl_ff <= ~load_tgl_ff;
            end else if (csn_fall && have_result_ff && !busy) begin
                load_tgl_ff <= ~load_tgl_ff;
            end
        end
    end
    // serial clock domain: the word is stable long before the toggle lands
    logic srst_a_ff, srst_b_ff, stg_a_ff, stg_b_ff, stg_seen_ff, sbit_ff;
    logic [3:0] sidx_ff;
    always_ff @(negedge serial_clk) begin
        srst_a_ff <= sys_rst;
        srst_b_ff <= srst_a_ff;
        stg_a_ff <= load_tgl_ff;
        stg_b_ff <= stg_a_ff;
    end
    always_ff @(negedge serial_clk) begin
        if (srst_b_ff) begin
            stg_seen_ff <= 1'b0;
            sidx_ff <= SER_IDX_EMPTY;
            sbit_ff <= 1'b0;
        end else if (stg_b_ff != stg_seen_ff) begin
            stg_seen_ff <= stg_b_ff;
            sbit_ff <= ser_word_ff[9];
            sidx_ff <= 4'h8;
        end else if (sidx_ff != SER_IDX_EMPTY) begin
            sbit_ff <= ser_word_ff[sidx_ff];
            sidx_ff <= sidx_ff - 4'h1;
        end else begin
            sbit_ff <= 1'b0;
        end
    end
    // serial pin back in the system domain
    logic sb_a_ff, sb_b_ff, sout_ff, soe_ff;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sb_a_ff <= 1'b0;
            sb_b_ff <= 1'b0;
            sout_ff <= 1'b0;
            soe_ff <= 1'b0;
        end else if (clk_en) begin
            sb_a_ff <= sbit_ff;
            sb_b_ff <= sb_a_ff;
            sout_ff <= busy ? 1'b0 : sb_b_ff;
            soe_ff <= ~csn_s;
        end
    end
    // front end outputs
    logic sh_ff, icr_ff;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sh_ff <= 1'b0;
            icr_ff <= 1'b0;
        end else if (clk_en) begin
            sh_ff <= (state_ff == ST_SAMPLE) && !start_edge;
            icr_ff <= (state_ff == ST_CONVERT) && !ext_present && !conv_done;
        end
    end

    assign sample_hold = sh_ff;
    assign dac_trial = trial_ff;
    assign int_clk_run = icr_ff;
    assign end_of_conversion_n = eoc_n_ff;
    assign data_out = pd_ff;
    assign data_oe = poe_ff;
    assign serial_out = sout_ff;
    assign serial_oe = soe_ff;

    // checks
    a_start_flag_high: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && start_edge |=> eoc_n_ff && state_ff == ST_SAMPLE)
        else $error("end flag not high after start");
    a_hold_no_restart: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && start_cond && start_prev_ff && state_ff == ST_SAMPLE
        && sample_cnt_ff != 10'(SAMPLE_CYC - 1) |=> sample_cnt_ff != 10'h000)
        else $error("held start restarted sampling");
    a_width_latched: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && start_edge |=> width8_ff == $past(bs_s))
        else $error("width not latched at start");
    a_low_bits_zero: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(eoc_n_ff) && width8_ff |-> result_ff[1:0] == 2'b00)
        else $error("narrow result low bits set");
    a_busy_float: assert property (@(posedge clk) disable iff (sys_rst)
        busy && $past(busy) |-> poe_ff == 10'h000 && eoc_n_ff)
        else $error("bus driven or flag low while busy");
    a_serial_low: assert property (@(posedge clk) disable iff (sys_rst)
        busy && $past(busy) && $past(clk_en) |-> !sout_ff)
        else $error("serial out not low while busy");
    a_done_loads: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(eoc_n_ff) |-> ser_word_ff == result_ff && state_ff == ST_IDLE)
        else $error("result registers disagree at done");
    a_sample_length: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && state_ff == ST_SAMPLE && sample_cnt_ff == 10'(SAMPLE_CYC - 1) && !start_edge
        |=> state_ff == ST_CONVERT && $past(sample_cnt_ff) == 10'h3e7)
        else $error("sampling period wrong");
    a_thirteen_ticks: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && conv_done |-> tick_cnt_ff == 4'hc ##1 (!busy || $past(start_edge)))
        else $error("conversion tick count wrong");
    a_ext_blocks_int: assert property (@(posedge clk) disable iff (sys_rst)
        $past(clk_en) && $past(ext_present) |-> !icr_ff)
        else $error("internal clock ran with external clock present");
    a_wide_read: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && rd_cond && ws_s && !start_edge |=> poe_ff == 10'h3ff && pd_ff == result_ff)
        else $error("wide read incorrect");
endmodule

// ### sim/sarac_host_model.sv
// host side model: analog input seen through the comparator, and the clocks the host makes
// assumes the trial word settles long before the converter samples the comparator
module sarac_host_model (
    // analog side
    input wire logic [9:0] dac_trial,
    input wire logic [9:0] level,
    output logic compare_above,
    // clocks made by the host
    input wire logic ext_run,
    input wire logic sample_hold,
    output logic conversion_clock,
    output logic serial_clk
);
    timeunit 1ns;
    timeprecision 100ps;

    // comparator keeps the trial bit while the input is at or above it
    assign compare_above = (level >= dac_trial);

    // external clock at 500 kHz; grounded whenever the internal clock is wanted
    // held high while sampling so no switching noise lands on the held input
    initial begin
        conversion_clock = 1'b0;
        serial_clk = 1'b0;
        forever begin
            #1000;
            if (!ext_run) begin
                conversion_clock = 1'b0;
            end else if (sample_hold) begin
                conversion_clock = 1'b1;
            end else begin
                conversion_clock = ~conversion_clock;
            end
        end
    end

    // one 15 ns serial period; the line stands low between frames and while converting
    task automatic sclk_pulse();
        serial_clk = 1'b1;
        #7.5;
        serial_clk = 1'b0;
        #7.5;
    endtask
endmodule

// ### sim/tb_sarac_top.sv
// self-checking bench for the converter control and readout block
// assumes the host model supplies comparator and clocks; only clk_en is tied
module tb_sarac_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk, sys_rst, clk_en, chip_enable, chip_select_n, read_convert;
    logic byte_select, width_select, conversion_clock, compare_above, serial_clk;
    logic sample_hold, int_clk_run, end_of_conversion_n, serial_out, serial_oe, ext_run;
    logic [9:0] dac_trial, data_out, data_oe, level;
    int fails = 0;
    int compares = 0;
    int n;

    // detection window outlasts the held-high sampling phase of the external clock
    sarac_top #(.EXT_TIMEOUT(1500)) u_dut (.clk, .sys_rst, .clk_en, .chip_enable,
        .chip_select_n, .read_convert, .byte_select, .width_select, .conversion_clock,
        .compare_above, .sample_hold, .dac_trial, .int_clk_run, .end_of_conversion_n,
        .data_out, .data_oe, .serial_clk, .serial_out, .serial_oe);

    sarac_host_model u_host (.dac_trial, .level, .compare_above, .ext_run, .sample_hold,
        .conversion_clock, .serial_clk);

    // 100 MHz system clock
    always #5 clk = ~clk;

    task automatic summarize();
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk_vec(input logic [9:0] got, input logic [9:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %b exp %b", $time, msg, got, exp);
        end
    endtask

    // control pins change only at the falling edge
    task automatic pins(input logic e, c, r, b, w);
        @(negedge clk);
        chip_enable = e;
        chip_select_n = c;
        read_convert = r;
        byte_select = b;
        width_select = w;
    endtask

    // parallel read; pins pass a synchroniser, so settle a few cycles first
    task automatic rd(input logic w, b, input logic [9:0] d, oe);
        pins(1'b1, 1'b0, 1'b1, b, w);
        repeat (5) @(negedge clk);
        chk_vec(data_out, d, "read data");
        chk_vec(data_oe, oe, "read enables");
    endtask

    // start by a falling convert line, then wait for the done flag
    task automatic conv(input logic b, input logic [9:0] lvl, output int cnt);
        level = lvl;
        pins(1'b1, 1'b0, 1'b1, b, 1'b0);
        pins(1'b1, 1'b0, 1'b0, b, 1'b0);
        repeat (500) @(negedge clk);
        chk_bit(end_of_conversion_n, 1'b1, "flag while busy");
        chk_vec(data_oe, 10'h000, "bus floats while busy");
        chk_bit(serial_out, 1'b0, "serial low while busy");
        chk_bit(serial_oe, 1'b1, "serial driven while busy");
        chk_bit(sample_hold, 1'b1, "sampling");
        cnt = 500;
        while (end_of_conversion_n !== 1'b0 && cnt < 9000) begin
            @(negedge clk);
            cnt++;
            if (cnt == 1020) begin
                chk_bit(sample_hold, 1'b0, "sampling over");
                chk_bit(int_clk_run, ~ext_run, "oscillator state");
            end
        end
        // a conversion that never ends is counted here
        chk_bit(end_of_conversion_n, 1'b0, "conversion finished");
    endtask

    // two falls cross the sync, then ten bits from the top and trailing zeros
    task automatic ser(input logic [9:0] d);
        repeat (5) @(negedge clk);
        repeat (2) u_host.sclk_pulse();
        for (int i = 9; i >= -2; i--) begin
            u_host.sclk_pulse();
            repeat (5) @(negedge clk);
            chk_bit(serial_out, (i >= 0) ? d[i] : 1'b0, "serial bit");
        end
    endtask

    // watchdog: the run needs about 17,000 cycles, so 40,000 means a hang
    initial begin
        #400_000;
        fails++;
        summarize();
    end

    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        clk_en = 1'b1;
        chip_enable = 1'b0;
        chip_select_n = 1'b1;
        read_convert = 1'b1;
        byte_select = 1'b0;
        width_select = 1'b0;
        ext_run = 1'b0;
        level = 10'h000;
        // the serial domain needs falls of its own clock to leave reset
        fork
            repeat (3) u_host.sclk_pulse();
        join_none
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk);
        chk_bit(end_of_conversion_n, 1'b1, "flag after reset");
        chk_vec(data_oe, 10'h000, "bus after reset");
        // full width on the internal clock; enable and select go active one cycle before the convert line falls
        conv(1'b0, 10'h2d7, n);
        chk_bit(n >= 6150 && n <= 6250, 1'b1, "internal conversion length");
        repeat (20) @(negedge clk);
        chk_bit(end_of_conversion_n, 1'b0, "held start does not restart");
        rd(1'b1, 1'b1, 10'h2d7, 10'h3ff);
        rd(1'b0, 1'b0, 10'h2d4, 10'h3fc);
        rd(1'b0, 1'b1, 10'h300, 10'h3fc);
        ser(10'h2d7);
        pins(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        repeat (5) @(negedge clk);
        chk_bit(serial_oe, 1'b0, "serial floats when deselected");
        chk_vec(data_oe, 10'h000, "bus floats when deselected");
        pins(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        ser(10'h2d7);
        // disabled chip ignores convert low and keeps the parallel bus off; serial_oe still follows select
        pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        repeat (50) @(negedge clk);
        chk_bit(end_of_conversion_n, 1'b0, "no start while disabled");
        chk_vec(data_oe, 10'h000, "no drive while disabled");
        // reduced width keeps the two low bits at zero
        conv(1'b1, 10'h2d7, n);
        rd(1'b1, 1'b0, 10'h2d4, 10'h3ff);
        // external clock present keeps the oscillator asleep
        ext_run = 1'b1;
        repeat (600) @(negedge clk);
        conv(1'b0, 10'h155, n);
        chk_bit(n >= 3390 && n <= 3620, 1'b1, "external conversion length");
        rd(1'b1, 1'b0, 10'h155, 10'h3ff);
        summarize();
    end
endmodule
